// ---- rtl/hbc_breakpoint.sv ----
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
`include "hbc_cfg.svh"
module hbc_breakpoint (
    // clock, enable, resets
    input wire logic clk,
    input wire logic clkEn,
    input wire logic srst,
    input wire logic porRst,
    // avalon-mm register slave
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // core bus
    input wire logic busValid,
    input wire logic [15:0] busAddr,
    input wire logic [15:0] busData,
    input wire logic busRead,
    input wire logic busFetch,
    input wire logic opExecuted,
    // debug unit
    input wire logic backgroundDebugActive,
    input wire logic backgroundDebugPermit,
    // breakpoint requests
    output logic softwareInterruptReq,
    output logic backgroundDebugReq,
    output hbc_pkg::hbc_mode_t modeOut
);
    import hbc_pkg::*;

    //--------------------------------------------------
    // registers
    //--------------------------------------------------
    logic [7:0] modeCtrl_reg;
    logic [7:0] qualCtrl_reg;
    logic [7:0] addrHi_reg;
    logic [7:0] addrLo_reg;
    logic [7:0] cmpHi_reg;
    logic [7:0] cmpLo_reg;
    hbc_bus_t busSt_reg;
    logic wrHit;
    logic rdHit;
    logic [7:0] rdByte;

    // waitrequest drops one cycle after a request appears; a write lands only on that
    // low edge, so the master never sees a register change while still waiting
    assign wrHit = avsWrite && busSt_reg == HBC_BUS_DONE && avsByteEnable[0];
    assign rdHit = avsRead && busSt_reg == HBC_BUS_IDLE;

    // bus handshake state
    always_ff @(posedge clk) begin
        if (srst) begin
            busSt_reg <= HBC_BUS_IDLE;
            avsWaitRequest <= 1'b1;
        end else if (clkEn) begin
            case (busSt_reg)
                HBC_BUS_IDLE: begin
                    if (avsRead || avsWrite) begin
                        busSt_reg <= HBC_BUS_DONE;
                        avsWaitRequest <= 1'b0;
                    end
                end
                default: begin
                    busSt_reg <= HBC_BUS_IDLE;
                    avsWaitRequest <= 1'b1;
                end
            endcase
        end
    end

    // read mux; unmapped words read as zero
    always_comb begin
        if (avsAddress == `HBC_OFS_MODE) begin
            rdByte = modeCtrl_reg;
        end else if (avsAddress == `HBC_OFS_QUAL) begin
            rdByte = qualCtrl_reg;
        end else if (avsAddress == `HBC_OFS_AH) begin
            rdByte = addrHi_reg;
        end else if (avsAddress == `HBC_OFS_AL) begin
            rdByte = addrLo_reg;
        end else if (avsAddress == `HBC_OFS_DH) begin
            rdByte = cmpHi_reg;
        end else if (avsAddress == `HBC_OFS_DL) begin
            rdByte = cmpLo_reg;
        end else begin
            rdByte = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avsReadData <= 32'h00000000;
        end else if (clkEn && rdHit) begin
            avsReadData <= {24'h000000, rdByte};
        end
    end

    // control registers follow ordinary reset
    always_ff @(posedge clk) begin
        if (srst || porRst) begin
            modeCtrl_reg <= `HBC_RST_CTRL;
            qualCtrl_reg <= `HBC_RST_CTRL;
        end else if (clkEn && wrHit) begin
            if (avsAddress == `HBC_OFS_MODE) begin
                modeCtrl_reg <= avsWriteData[7:0] & `HBC_MODE_WMASK;
            end else if (avsAddress == `HBC_OFS_QUAL) begin
                qualCtrl_reg <= avsWriteData[7:0] & `HBC_QUAL_WMASK;
            end
        end
    end

    // compare values survive ordinary reset; the mode register clears, so no break fires until the mode is set again
    always_ff @(posedge clk) begin
        if (porRst) begin
            addrHi_reg <= `HBC_RST_CMP;
            addrLo_reg <= `HBC_RST_CMP;
            cmpHi_reg <= `HBC_RST_CMP;
            cmpLo_reg <= `HBC_RST_CMP;
        end else if (clkEn && wrHit) begin
            if (avsAddress == `HBC_OFS_AH) begin
                addrHi_reg <= avsWriteData[7:0];
            end else if (avsAddress == `HBC_OFS_AL) begin
                addrLo_reg <= avsWriteData[7:0];
            end else if (avsAddress == `HBC_OFS_DH) begin
                cmpHi_reg <= avsWriteData[7:0];
            end else if (avsAddress == `HBC_OFS_DL) begin
                cmpLo_reg <= avsWriteData[7:0];
            end
        end
    end

    //--------------------------------------------------
    // comparators
    //--------------------------------------------------
    hbc_mode_t mode;
    logic pOnly, sce, dualMode, ignoreQual;
    logic bp0Hit, bp1Hit, fullHit, dirOk0, dirOk1;
    logic progOk, anyHit;

    assign mode = hbc_mode_t'({modeCtrl_reg[`HBC_MODE_HI], modeCtrl_reg[`HBC_MODE_LO]});
    // program-only is forced in interrupt mode, bit itself ignored there
    assign pOnly = (mode == HBC_SWI_DUAL) || modeCtrl_reg[`HBC_PONLY];
    assign sce = qualCtrl_reg[`HBC_SCE];
    assign dualMode = (mode == HBC_SWI_DUAL) || (mode == HBC_DBG_DUAL);
    // qualifiers dropped in interrupt mode and on any program-only break
    assign ignoreQual = pOnly;

    // direction checks, busRead high is a read cycle
    assign dirOk0 = ignoreQual || !qualCtrl_reg[`HBC_BP0RWE]
                    || (qualCtrl_reg[`HBC_BP0RW] == busRead);
    assign dirOk1 = ignoreQual || !qualCtrl_reg[`HBC_BP1RWE]
                    || (qualCtrl_reg[`HBC_BP1RW] == busRead);

    // breakpoint zero, used in full and dual modes
    assign bp0Hit = (busAddr[15:8] == addrHi_reg)
                    && (!modeCtrl_reg[`HBC_BP0ALE] || busAddr[7:0] == addrLo_reg)
                    && dirOk0;

    // breakpoint one uses second compare registers as address, masks never used
    assign bp1Hit = dualMode && sce
                    && (busAddr[15:8] == cmpHi_reg)
                    && (!modeCtrl_reg[`HBC_BP1ALE] || busAddr[7:0] == cmpLo_reg)
                    && dirOk1;

    // full mode data stage; breakpoint-one bits not consulted here
    assign fullHit = bp0Hit && (pOnly || !sce
                     || ((qualCtrl_reg[`HBC_MASKH] || busData[15:8] == cmpHi_reg)
                     && (qualCtrl_reg[`HBC_MASKL] || busData[7:0] == cmpLo_reg)));

    // program-only breaks need an executed fetch (tag travels with the opcode)
    assign progOk = !pOnly || (busFetch && opExecuted);

    always_comb begin
        case (mode)
            HBC_DBG_FULL: anyHit = fullHit;
            HBC_SWI_DUAL, HBC_DBG_DUAL: anyHit = bp0Hit || bp1Hit;
            default: anyHit = 1'b0;
        endcase
    end

    //--------------------------------------------------
    // request outputs
    //--------------------------------------------------
    logic fire;
    assign fire = busValid && anyHit && progOk && !backgroundDebugActive;

    // permit is not checked for software interrupts; debug entry needs it
    always_ff @(posedge clk) begin
        if (srst) begin
            softwareInterruptReq <= 1'b0;
            backgroundDebugReq <= 1'b0;
            modeOut <= HBC_OFF;
        end else if (clkEn) begin
            softwareInterruptReq <= fire && mode == HBC_SWI_DUAL;
            backgroundDebugReq <= fire && mode[1] && backgroundDebugPermit;
            modeOut <= mode;
        end
    end

    //--------------------------------------------------
    // checks
    //--------------------------------------------------
    a_no_break_active: assert property (@(posedge clk) disable iff (srst)
        clkEn && backgroundDebugActive |=> !softwareInterruptReq && !backgroundDebugReq)
        else $error("break raised while debug active");
    a_swi_mode_only: assert property (@(posedge clk) disable iff (srst)
        softwareInterruptReq |-> $past(mode) == HBC_SWI_DUAL)
        else $error("software interrupt outside its mode");
    a_dbg_permit: assert property (@(posedge clk) disable iff (srst)
        backgroundDebugReq |-> $past(backgroundDebugPermit) && $past(mode[1]))
        else $error("debug request without permit");
    a_off_silent: assert property (@(posedge clk) disable iff (srst)
        clkEn && mode == HBC_OFF |=> !softwareInterruptReq && !backgroundDebugReq)
        else $error("break while off");
    a_prog_only: assert property (@(posedge clk) disable iff (srst)
        clkEn && pOnly && !busFetch |=> !softwareInterruptReq && !backgroundDebugReq)
        else $error("program break on non fetch");
    a_hi_addr_full: assert property (@(posedge clk) disable iff (srst)
        clkEn && mode == HBC_DBG_FULL && busAddr[15:8] != addrHi_reg |=> !backgroundDebugReq)
        else $error("full break on wrong high address");
    a_bp1_needs_sce: assert property (@(posedge clk) disable iff (srst)
        clkEn && dualMode && !sce && !bp0Hit |=> !softwareInterruptReq && !backgroundDebugReq)
        else $error("second break without enable");
    a_bus_ack_once: assert property (@(posedge clk) disable iff (srst)
        clkEn && !avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low two cycles");

    // a request seen while the bus handshake is idle is answered on the next edge
    a_bus_answer: assert property (@(posedge clk) disable iff (srst)
        clkEn && (avsRead || avsWrite) && busSt_reg == HBC_BUS_IDLE |=> !avsWaitRequest)
        else $error("request not answered");

    // unused control bits never hold a one
    a_qual_spare: assert property (@(posedge clk) disable iff (srst)
        qualCtrl_reg[4] == 1'b0)
        else $error("qualifier spare bit set");
    a_mode_spare: assert property (@(posedge clk) disable iff (srst)
        modeCtrl_reg[4:2] == 3'b000)
        else $error("mode spare bits set");

    // the mode output tracks the decoded mode one cycle late
    a_mode_track: assert property (@(posedge clk) disable iff (srst)
        clkEn |=> modeOut == $past(mode))
        else $error("mode output stale");

    // no request without a valid bus cycle
    a_need_valid: assert property (@(posedge clk) disable iff (srst)
        clkEn && !busValid |=> !softwareInterruptReq && !backgroundDebugReq)
        else $error("break without bus cycle");

    // a qualifying match must actually raise its request
    a_swi_raised: assert property (@(posedge clk) disable iff (srst)
        clkEn && fire && mode == HBC_SWI_DUAL |=> softwareInterruptReq)
        else $error("software interrupt missed");
    a_dbg_raised: assert property (@(posedge clk) disable iff (srst)
        clkEn && fire && mode[1] && backgroundDebugPermit |=> backgroundDebugReq)
        else $error("debug request missed");

    // each mode drives only its own request line
    a_dbg_no_swi: assert property (@(posedge clk) disable iff (srst)
        clkEn && mode[1] |=> !softwareInterruptReq)
        else $error("software interrupt in debug mode");
    a_swi_no_dbg: assert property (@(posedge clk) disable iff (srst)
        clkEn && mode == HBC_SWI_DUAL |=> !backgroundDebugReq)
        else $error("debug request in interrupt mode");

    // full mode data bytes, when compared, must agree
    a_full_data_hi: assert property (@(posedge clk) disable iff (srst)
        clkEn && mode == HBC_DBG_FULL && !pOnly && sce && !qualCtrl_reg[`HBC_MASKH]
        && busData[15:8] != cmpHi_reg |=> !backgroundDebugReq)
        else $error("full break on wrong high data");
    a_full_data_lo: assert property (@(posedge clk) disable iff (srst)
        clkEn && mode == HBC_DBG_FULL && !pOnly && sce && !qualCtrl_reg[`HBC_MASKL]
        && busData[7:0] != cmpLo_reg |=> !backgroundDebugReq)
        else $error("full break on wrong low data");

    // low address byte counts once its range bit is set
    a_full_lo_addr: assert property (@(posedge clk) disable iff (srst)
        clkEn && mode == HBC_DBG_FULL && modeCtrl_reg[`HBC_BP0ALE]
        && busAddr[7:0] != addrLo_reg |=> !backgroundDebugReq)
        else $error("full break on wrong low address");

    // power-on clears every compare register
    a_cmp_por: assert property (@(posedge clk) disable iff (srst)
        porRst |=> addrHi_reg == 8'h00 && addrLo_reg == 8'h00
        && cmpHi_reg == 8'h00 && cmpLo_reg == 8'h00)
        else $error("compare registers kept over power-on");
endmodule

// ---- rtl/hbc_cfg.svh ----
// Notes on behaviour
// - mode bits 00 off, 01 interrupt dual, 10 debug full, 11 debug dual.
// - no breakpoint fires while background debug is already active.
// - only interrupt dual mode raises a software interrupt; program fetches only there.
// - interrupt dual mode ignores direction and byte masks; range bits still apply.
// - dual modes: second-compare enable arms breakpoint one using second compare registers.
// - full mode ignores breakpoint-one range and direction bits.
// - full mode: enable data compare and masks, all ignored when program-only set.
// - dual modes ignore both data byte masks.
// - debug entry requested only when the debug unit permits it.
// - debug dual with program-only ignores direction and mask settings.
// - program-only clear breaks on any match; set breaks only on executed opcodes.
// - program-only bit has no effect in interrupt dual mode.
// - breakpoint zero range bit picks upper byte or full 16-bit address.
// - breakpoint one range bit adds low second compare byte in dual mode.
// - second compare registers unused when second-compare enable is clear.
// - full mode high mask clear compares data 15:8 with high second compare.
// - full mode low mask clear compares data 7:0 with low second compare.
// - breakpoint zero direction enable; value 0 writes, 1 reads, else don't care.
// - breakpoint one direction only in dual mode with second compare enabled.
// - qualifier control register at 0x21 is read/write in all modes.
// - high address compare matches the address bus upper byte.
// - low address compare matches the low address byte when range bit set.
// - four compare registers clear on power-on only, not on ordinary reset.
`ifndef HBC_CFG_SVH
`define HBC_CFG_SVH
`define HBC_OFS_MODE 8'h20
`define HBC_OFS_QUAL 8'h21
`define HBC_OFS_AH 8'h24
`define HBC_OFS_AL 8'h25
`define HBC_OFS_DH 8'h26
`define HBC_OFS_DL 8'h27
// mode register fields
`define HBC_MODE_HI 7
`define HBC_MODE_LO 6
`define HBC_PONLY 5
`define HBC_BP1ALE 1
`define HBC_BP0ALE 0
// qualifier register fields
`define HBC_SCE 7
`define HBC_MASKH 6
`define HBC_MASKL 5
`define HBC_BP1RWE 3
`define HBC_BP1RW 2
`define HBC_BP0RWE 1
`define HBC_BP0RW 0
`define HBC_MODE_WMASK 8'hE3
`define HBC_QUAL_WMASK 8'hEF
`define HBC_RST_CTRL 8'h00
`define HBC_RST_CMP 8'h00
`endif

// ---- rtl/hbc_pkg.sv ----
package hbc_pkg;
    typedef enum logic [1:0] {
        HBC_OFF = 2'b00,
        HBC_SWI_DUAL = 2'b01,
        HBC_DBG_FULL = 2'b10,
        HBC_DBG_DUAL = 2'b11
    } hbc_mode_t;
    typedef enum logic [1:0] {
        HBC_BUS_IDLE = 2'b00,
        HBC_BUS_DONE = 2'b01
    } hbc_bus_t;
endpackage

// ---- verif/hbc_core_model.sv ----
`timescale 1ns/100ps
module hbc_core_model (
    // clock
    input wire logic clk,
    // core bus
    output logic busValid,
    output logic [15:0] busAddr,
    output logic [15:0] busData,
    output logic busRead,
    output logic busFetch,
    output logic opExecuted
);
    // bus parked idle with a non-matching pattern
    initial begin
        busValid = 1'b0;
        busAddr = 16'hFFFF;
        busData = 16'hFFFF;
        {busRead, busFetch, opExecuted} = 3'b000;
    end
    // one bus cycle; afterwards the lines float to the inverse, never a stale copy
    task automatic cycle(input logic [15:0] a, input logic [15:0] d, input logic [2:0] k);
        @(posedge clk);
        busValid <= 1'b1;
        busAddr <= a;
        busData <= d;
        {busRead, busFetch, opExecuted} <= k; // fetch plus execute marks a tagged opcode
        @(posedge clk);
        busValid <= 1'b0;
        busAddr <= ~a;
        busData <= ~d;
        {busRead, busFetch, opExecuted} <= ~k;
    endtask
endmodule

// ---- verif/hbc_breakpoint_tb_top.sv ----
`timescale 1ns/100ps
module hbc_breakpoint_tb_top;
    import hbc_pkg::*;
    localparam logic [2:0] F = 3'b111;
    localparam logic [2:0] NX = 3'b110;
    localparam logic [2:0] R = 3'b100;
    localparam logic [2:0] W = 3'b000;
    localparam logic [7:0] OFS [6] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h27};
    logic clk = 1'b0, srst = 1'b1, porRst = 1'b1, dbgActive = 1'b0, dbgPermit = 1'b1;
    logic [7:0] avsAddress = 8'h00;
    logic avsRead = 1'b0, avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [3:0] avsByteEnable = 4'hF;
    logic [31:0] avsReadData;
    logic avsWaitRequest, busValid, busRead, busFetch, opExecuted, swiReq, dbgReq;
    logic [15:0] busAddr, busData;
    hbc_mode_t modeOut;
    int fail_count = 0, num_checks = 0, cyc = 0;
    hbc_core_model core (.clk(clk), .busValid(busValid), .busAddr(busAddr), .busData(busData),
        .busRead(busRead), .busFetch(busFetch), .opExecuted(opExecuted));
    hbc_breakpoint uut (.clk(clk), .clkEn(1'b1), .srst(srst), .porRst(porRst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .busValid(busValid), .busAddr(busAddr),
        .busData(busData), .busRead(busRead), .busFetch(busFetch), .opExecuted(opExecuted),
        .backgroundDebugActive(dbgActive), .backgroundDebugPermit(dbgPermit),
        .softwareInterruptReq(swiReq), .backgroundDebugReq(dbgReq), .modeOut(modeOut));
    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end
    // a hung handshake ends the run as a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWriteData <= {24'h0, d};
        avsWrite <= 1'b1;
        do @(posedge clk); while (avsWaitRequest !== 1'b0);
        avsWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        avsAddress <= a;
        avsRead <= 1'b1;
        do @(posedge clk); while (avsWaitRequest !== 1'b0);
        chk("readData", avsReadData, {24'h0, exp});
        avsRead <= 1'b0;
    endtask
    // one core cycle; the request answers on the edge after the matching cycle
    task automatic bp(input logic [15:0] a, input logic [15:0] d, input logic [2:0] k,
        input logic [1:0] e);
        core.cycle(a, d, k);
        #1;
        chk("swiReq_dbgReq", {30'h0, swiReq, dbgReq}, {30'h0, e});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        porRst <= 1'b0;
        foreach (OFS[i]) rd(OFS[i], 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h21, 8'hFF);
        rd(8'h21, 8'hEF);
        wr(8'h24, 8'h12);
        wr(8'h25, 8'h34);
        wr(8'h26, 8'h56);
        wr(8'h27, 8'h78);
        wr(8'h30, 8'h99);
        avsByteEnable <= 4'h0;
        wr(8'h24, 8'hAA);
        avsByteEnable <= 4'hF;
        rd(8'h24, 8'h12);
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        rd(8'h24, 8'h12);
        rd(8'h27, 8'h78);
        $display("test registers done");
        // interrupt dual mode, program-only set but meaningless here
        wr(8'h20, 8'h60);
        wr(8'h21, 8'h02);
        bp(16'h12FF, 16'h0, F, 2'b10);
        bp(16'h1234, 16'h0, R, 2'b00);
        bp(16'h1234, 16'h0, NX, 2'b00);
        wr(8'h20, 8'h41);
        bp(16'h12FF, 16'h0, F, 2'b00);
        bp(16'h5678, 16'h0, F, 2'b00);
        wr(8'h21, 8'h82);
        bp(16'h56AA, 16'h0, F, 2'b10);
        wr(8'h20, 8'h43);
        bp(16'h56AA, 16'h0, F, 2'b00);
        chk("modeOut", {30'h0, modeOut}, {30'h0, HBC_SWI_DUAL});
        $display("test interrupt dual done");
        // full breakpoint mode with data compare
        wr(8'h20, 8'h81);
        wr(8'h21, 8'h80);
        bp(16'h1234, 16'h5678, W, 2'b01);
        bp(16'h1234, 16'h5600, W, 2'b00);
        wr(8'h21, 8'hA0);
        bp(16'h1234, 16'h5600, W, 2'b01);
        wr(8'h21, 8'hCB);
        bp(16'h1234, 16'h0078, W, 2'b00);
        bp(16'h1234, 16'h0078, R, 2'b01);
        bp(16'h1235, 16'h0078, R, 2'b00);
        @(posedge clk) dbgActive <= 1'b1;
        bp(16'h1234, 16'h0078, R, 2'b00);
        @(posedge clk) dbgActive <= 1'b0;
        dbgPermit <= 1'b0; // debug entry blocked without permit
        bp(16'h1234, 16'h0078, R, 2'b00);
        @(posedge clk) dbgPermit <= 1'b1;
        chk("modeOut", {30'h0, modeOut}, {30'h0, HBC_DBG_FULL});
        $display("test full mode done");
        // debug dual with program-only, then breakpoints off
        wr(8'h20, 8'hE1);
        wr(8'h21, 8'h62);
        bp(16'h1234, 16'h0, F, 2'b01);
        bp(16'h1234, 16'h0, NX, 2'b00);
        wr(8'h20, 8'h01);
        bp(16'h1234, 16'h0, F, 2'b00);
        chk("modeOut", {30'h0, modeOut}, {30'h0, HBC_OFF});
        $display("test dual and off done");
        close_out();
    end
endmodule
